//--- hw/sps_stepper_phase_sequencer.sv
// Top of the stepper phase sequencer: pin sampling, phase stepping,
// gate outputs and an AXI4-Lite register slave.
// Assumes all step-side pins are asynchronous to CLOCK_I.
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_stepper_phase_sequencer
  import sps_pkg::*;
#(
  parameter int unsigned MIN_PULSE_CYC = `SPS_STEP_MIN_PULSE_CYC,
  parameter int unsigned ADDR_W = 8
)(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic STEP_CLK_I,
  input wire logic DIRECTION_SELECT_I,
  input wire logic MODE_I,
  input wire logic ENABLE_I,
  input wire logic RESET_LOW_INPUT_N_I,
  output logic FIRST_GATE_O,
  output logic COIL_TWO_FWD_O,
  output logic COIL_ONE_REV_O,
  output logic COIL_TWO_REV_O,
  input wire logic [ADDR_W-1:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I
);

  localparam int unsigned LEN_W = $clog2(MIN_PULSE_CYC + 1);

  logic [4:0] pin_s;
  logic step_s;
  logic dir_s;
  sps_mode_t mode_s;
  logic en_s;
  logic rst_pin_s;
  logic step_d;
  logic step_rise;
  logic step_edge;
  logic seq_rst;
  logic gate_ok;
  logic [2:0] pos;
  logic [2:0] eff;
  logic [2:0] next_pos;
  logic [3:0] coils;
  logic [31:0] count;
  logic [LEN_W-1:0] len;
  logic seen_edge;
  logic pulse_err;
  logic sw_en;
  sps_bus_state_t wst;
  sps_bus_state_t rst_st;
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic ctrl_hit;
  logic cnt_clr;
  logic err_clr;
  logic [31:0] status_word;

  // Pin synchronisers
  sps_sync #(.WIDTH(5)) u_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .d_i({RESET_LOW_INPUT_N_I, ENABLE_I, MODE_I, DIRECTION_SELECT_I, STEP_CLK_I}),
    .q_o(pin_s)
  );

  assign step_s = pin_s[0];
  assign dir_s = pin_s[1];
  assign mode_s = sps_mode_t'(pin_s[2]);
  assign en_s = pin_s[3];
  assign rst_pin_s = pin_s[4];
  assign seq_rst = ~rst_pin_s;

  // Step clock edge detection on the synchronised level
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      step_d <= 1'b0;
    end else begin
      step_d <= step_s;
    end
  end

  assign step_rise = step_s & ~step_d;
  assign step_edge = step_s ^ step_d;

  // Shown position and next position
  always_comb begin
    eff = pos;
    if (mode_s == SPS_MODE_FULL && !pos[0]) begin
      eff = pos - 3'h1;
    end
    if (mode_s == SPS_MODE_HALF) begin
      next_pos = dir_s ? pos - 3'h1 : pos + 3'h1;
    end else begin
      next_pos = dir_s ? eff - 3'h2 : eff + 3'h2;
    end
  end

  // Sequence position, kept while clock is still, stepped even while enable is low
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pos <= `SPS_POS_RESET;
    end else if (seq_rst) begin
      pos <= `SPS_POS_RESET;
    end else if (step_rise) begin
      pos <= next_pos;
    end
  end

  assign gate_ok = rst_pin_s & en_s & sw_en;

  // Registered winding gate outputs
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      coils <= 4'h0;
    end else if (gate_ok) begin
      coils <= sps_pattern(eff);
    end else begin
      coils <= 4'h0;
    end
  end

  assign FIRST_GATE_O = coils[0];
  assign COIL_TWO_FWD_O = coils[1];
  assign COIL_ONE_REV_O = coils[2];
  assign COIL_TWO_REV_O = coils[3];

  // Signed half-step position count
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      count <= 32'h0000_0000;
    end else begin
      if (cnt_clr || seq_rst) begin
        count <= 32'h0000_0000;
      end else if (step_rise) begin
        if (mode_s == SPS_MODE_HALF) begin
          count <= dir_s ? count - 32'h0000_0001 : count + 32'h0000_0001;
        end else begin
          count <= dir_s ? count - 32'h0000_0002 : count + 32'h0000_0002;
        end
      end
    end
  end

  // Step clock level length, saturating
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      len <= '0;
      seen_edge <= 1'b0;
    end else if (step_edge) begin
      len <= '0;
      seen_edge <= 1'b1;
    end else if (len != LEN_W'(MIN_PULSE_CYC)) begin
      len <= len + LEN_W'(1);
    end
  end

  // Sticky short-pulse flag; a new error wins over a clear
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pulse_err <= 1'b0;
    end else if (step_edge && seen_edge && len < LEN_W'(MIN_PULSE_CYC - 1)) begin
      pulse_err <= 1'b1;
    end else if (err_clr) begin
      pulse_err <= 1'b0;
    end
  end

  // Write channel handshakes
  assign AXI_AWREADY_O = (wst == SPS_BUS_IDLE) && !aw_hold;
  assign AXI_WREADY_O = (wst == SPS_BUS_IDLE) && !w_hold;
  assign AXI_BVALID_O = (wst == SPS_BUS_RESP);
  assign do_write = (wst == SPS_BUS_IDLE) && aw_hold && w_hold;
  assign ctrl_hit = do_write && aw_addr == ADDR_W'(`SPS_CTRL_OFS) && w_strb[0];
  assign cnt_clr = ctrl_hit && w_data[`SPS_CTRL_CNT_CLR_BIT];
  assign err_clr = ctrl_hit && w_data[`SPS_CTRL_ERR_CLR_BIT];

  // Write address and data capture in either order
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (do_write) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
    end else begin
      if (AXI_AWVALID_I && AXI_AWREADY_O) begin
        aw_hold <= 1'b1;
        aw_addr <= AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && AXI_WREADY_O) begin
        w_hold <= 1'b1;
        w_data <= AXI_WDATA_I;
        w_strb <= AXI_WSTRB_I;
      end
    end
  end

  // Write state and response
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wst <= SPS_BUS_IDLE;
      AXI_BRESP_O <= `SPS_RESP_OKAY;
    end else begin
      case (wst)
        SPS_BUS_IDLE: begin
          if (do_write) begin
            wst <= SPS_BUS_RESP;
            AXI_BRESP_O <= (aw_addr == ADDR_W'(`SPS_CTRL_OFS)) ? `SPS_RESP_OKAY
                                                                : `SPS_RESP_SLVERR;
          end
        end
        SPS_BUS_RESP: begin
          if (AXI_BREADY_I) begin
            wst <= SPS_BUS_IDLE;
          end
        end
        default: wst <= SPS_BUS_IDLE;
      endcase
    end
  end

  // Software gate enable
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sw_en <= `SPS_CTRL_RESET;
    end else if (ctrl_hit) begin
      sw_en <= w_data[`SPS_CTRL_SW_EN_BIT];
    end
  end

  // Status word assembly
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SPS_ST_POS_LSB +: 3] = pos;
    status_word[`SPS_ST_MODE_BIT] = mode_s;
    status_word[`SPS_ST_DIR_BIT] = dir_s;
    status_word[`SPS_ST_COIL_LSB +: 4] = coils;
    status_word[`SPS_ST_SEQRST_BIT] = seq_rst;
    status_word[`SPS_ST_ERR_BIT] = pulse_err;
  end

  assign AXI_ARREADY_O = (rst_st == SPS_BUS_IDLE);
  assign AXI_RVALID_O = (rst_st == SPS_BUS_RESP);

  // Read state, data and response
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_st <= SPS_BUS_IDLE;
      AXI_RDATA_O <= 32'h0000_0000;
      AXI_RRESP_O <= `SPS_RESP_OKAY;
    end else begin
      case (rst_st)
        SPS_BUS_IDLE: begin
          if (AXI_ARVALID_I) begin
            rst_st <= SPS_BUS_RESP;
            AXI_RRESP_O <= `SPS_RESP_OKAY;
            case (AXI_ARADDR_I)
              ADDR_W'(`SPS_CTRL_OFS): AXI_RDATA_O <= {31'h0000_0000, sw_en};
              ADDR_W'(`SPS_STATUS_OFS): AXI_RDATA_O <= status_word;
              ADDR_W'(`SPS_COUNT_OFS): AXI_RDATA_O <= count;
              default: begin
                AXI_RDATA_O <= 32'h0000_0000;
                AXI_RRESP_O <= `SPS_RESP_SLVERR;
              end
            endcase
          end
        end
        SPS_BUS_RESP: begin
          if (AXI_RREADY_I) begin
            rst_st <= SPS_BUS_IDLE;
          end
        end
        default: rst_st <= SPS_BUS_IDLE;
      endcase
    end
  end

  // Checks on the sequencer behaviour
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_reset_start_pos: assert property (seq_rst |=> pos == 3'h0)
    else $error("sequencer did not return to start position");
  a_reset_gates_off: assert property (seq_rst |=> coils == 4'h0)
    else $error("gates on while sequencer reset low");
  a_step_only_rise: assert property (!step_rise && !seq_rst |=> $stable(pos))
    else $error("position moved without a rising step edge");
  a_half_forward: assert property (step_rise && !seq_rst && !dir_s
      && mode_s == SPS_MODE_HALF |=> pos == $past(pos) + 3'h1)
    else $error("half step forward did not advance by one");
  a_half_reverse: assert property (step_rise && !seq_rst && dir_s
      && mode_s == SPS_MODE_HALF |=> pos == $past(pos) - 3'h1)
    else $error("half step reverse did not go back by one");
  a_enable_off: assert property (!en_s |=> coils == 4'h0)
    else $error("gates on while enable low");
  a_full_two_coils: assert property (gate_ok && mode_s == SPS_MODE_FULL
      |=> $countones(coils) == 2)
    else $error("full step did not drive a winding pair");
  a_full_order: assert property (gate_ok && step_rise && !dir_s && !seq_rst
      && mode_s == SPS_MODE_FULL ##1 gate_ok && mode_s == SPS_MODE_FULL
      |=> (coils & $past(coils, 2)) != 4'h0 && coils != $past(coils, 2))
    else $error("full step pair did not share one winding with the last");
  a_half_alternate: assert property (gate_ok && mode_s == SPS_MODE_HALF
      |=> $countones(coils) == ($past(eff[0]) ? 2 : 1))
    else $error("half step single and paired states out of order");
  a_mode_keeps_pos: assert property ($changed(mode_s) && !step_rise && !seq_rst
      |=> $stable(pos))
    else $error("mode change moved the position");
  a_resume_same: assert property ($rose(en_s) && sw_en && rst_pin_s && !step_rise
      |=> coils == sps_pattern($past(eff)))
    else $error("outputs did not resume at kept position");

  c_full_step: cover property (step_rise && mode_s == SPS_MODE_FULL && gate_ok);
  c_half_reverse: cover property (step_rise && mode_s == SPS_MODE_HALF && dir_s);
  c_enable_resume: cover property ($rose(en_s) && rst_pin_s);
  c_mode_switch: cover property ($changed(mode_s) && rst_pin_s);

endmodule

//--- hw/sps_regs.svh
// Register map, field positions, reset values and timing counts of the
// stepper phase sequencer; assumes a 100 MHz system clock.
// Operation
// - After reset, first gate switches on first
// - Only step clock rising edges advance pattern
// - Direction level picks forward or backward stepping
// - Direction low forward, high reverse rotation
// - Enable low forces all four gates off
// - Enable high resumes from kept sequence position; the code still steps the position while enable is low
// - Mode low full step, high half step
// - Mode change keeps present phase position
// - Static step clock holds present outputs energised
// - Full step: each gate on two periods
// - Half step: each gate on three periods
// - Reset low clears sequencer, gates off
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// Register byte offsets
`define SPS_CTRL_OFS 8'h00
`define SPS_STATUS_OFS 8'h04
`define SPS_COUNT_OFS 8'h08

// Control fields
`define SPS_CTRL_SW_EN_BIT 0
`define SPS_CTRL_CNT_CLR_BIT 1
`define SPS_CTRL_ERR_CLR_BIT 2
`define SPS_CTRL_RESET 1'b1

// Status fields
`define SPS_ST_POS_LSB 0
`define SPS_ST_MODE_BIT 3
`define SPS_ST_DIR_BIT 4
`define SPS_ST_COIL_LSB 5
`define SPS_ST_SEQRST_BIT 9
`define SPS_ST_ERR_BIT 10

// Sequence start position and bus answers
`define SPS_POS_RESET 3'h0
`define SPS_RESP_OKAY 2'h0
`define SPS_RESP_SLVERR 2'h2

// Timing
`define SPS_CLK_PERIOD_NS 10
`define SPS_STEP_MIN_PULSE_NS 10000
`define SPS_STEP_MIN_PULSE_CYC \
  ((`SPS_STEP_MIN_PULSE_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS)

`endif

//--- hw/sps_pkg.sv
// Types of the stepper phase sequencer: modes, bus states, winding table.
// Assumes the coil vector order {coil_two_rev, coil_one_rev, coil_two_fwd, first_gate}.
package sps_pkg;

  typedef enum logic {
    SPS_MODE_FULL = 1'b0,
    SPS_MODE_HALF = 1'b1
  } sps_mode_t;

  typedef enum logic [1:0] {
    SPS_BUS_IDLE = 2'b01,
    SPS_BUS_RESP = 2'b10
  } sps_bus_state_t;

  // Winding pattern for each of the eight half-step positions
  function automatic logic [3:0] sps_pattern(input logic [2:0] pos);
    logic [3:0] p;
    p = 4'h0;
    case (pos)
      3'h0: p = 4'h1;
      3'h1: p = 4'h3;
      3'h2: p = 4'h2;
      3'h3: p = 4'h6;
      3'h4: p = 4'h4;
      3'h5: p = 4'hC;
      3'h6: p = 4'h8;
      3'h7: p = 4'h9;
      default: p = 4'h0;
    endcase
    return p;
  endfunction

endpackage

//--- hw/sps_sync.sv
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
module sps_sync #(
  parameter int unsigned WIDTH = 1
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

//--- verif/sps_motion_ctl.sv
// Behavioural motion controller that drives the step-side pins of the sequencer.
// Assumes a free-running system clock for pacing; the step clock keeps its own phase.
`timescale 1ns/1ps
module sps_motion_ctl (
  input wire logic clk_i,
  output logic step_clk_o,
  output logic dir_o,
  output logic mode_o,
  output logic en_o,
  output logic rst_low_n_o
);
  // Power-up levels: step clock parked low, reset asserted, enable already high
  initial begin
    step_clk_o = 1'b0;
    dir_o = 1'b0;
    mode_o = 1'b1;
    en_o = 1'b1;
    rst_low_n_o = 1'b0;
  end

  // Sequencer reset held low for n system cycles
  task automatic hold_reset(input int n);
    @(posedge clk_i);
    rst_low_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rst_low_n_o <= 1'b1;
  endtask

  // Output enable level change
  task automatic set_en(input logic e);
    @(posedge clk_i);
    en_o <= e;
  endtask

  // One 80 ns step period; direction and mode settle half a period before the rise
  task automatic pulse(input logic d, input logic m);
    @(posedge clk_i);
    dir_o <= d;
    mode_o <= m;
    repeat (4) @(posedge clk_i);
    step_clk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    step_clk_o <= 1'b0;
  endtask

  // Step clock high for one system cycle only, to trip the short-pulse flag
  task automatic glitch();
    @(posedge clk_i);
    step_clk_o <= 1'b1;
    @(posedge clk_i);
    step_clk_o <= 1'b0;
  endtask
endmodule

//--- verif/sps_testbench.sv
// Self-checking bench of the stepper phase sequencer: pin stepping and register bus.
// Assumes the motion controller model drives all step-side pins.
`timescale 1ns/1ps
`include "sps_regs.svh"
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (e)); \
  end \
end
module testbench
  import sps_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic step, dir, mode, en, srst_n;
  wire [3:0] gates;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] pos = 3'h0;
  int cnt = 0;
  int err_total = 0;
  int checked = 0;

  // System clock, 100 MHz
  always #5 clk = ~clk;

  // Short pulse limit shortened to fit the 80 ns step period
  sps_stepper_phase_sequencer #(.MIN_PULSE_CYC(3), .ADDR_W(8)) dut_u (
    .CLOCK_I(clk), .RST_N_I(rst_n), .STEP_CLK_I(step), .DIRECTION_SELECT_I(dir),
    .MODE_I(mode), .ENABLE_I(en), .RESET_LOW_INPUT_N_I(srst_n),
    .FIRST_GATE_O(gates[0]), .COIL_TWO_FWD_O(gates[1]), .COIL_ONE_REV_O(gates[2]),
    .COIL_TWO_REV_O(gates[3]), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
    .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb),
    .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
    .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
    .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata),
    .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready));

  sps_motion_ctl ctl_u (.clk_i(clk), .step_clk_o(step), .dir_o(dir), .mode_o(mode),
    .en_o(en), .rst_low_n_o(srst_n));

  // Winding set {coil_two_rev, coil_one_rev, coil_two_fwd, first_gate} per position
  function automatic logic [3:0] exp_g(input logic [2:0] p, input logic half);
    logic [2:0] q;
    q = (half || p[0]) ? p : p - 3'h1;
    case (q)
      3'h0: exp_g = 4'h1;
      3'h1: exp_g = 4'h3;
      3'h2: exp_g = 4'h2;
      3'h3: exp_g = 4'h6;
      3'h4: exp_g = 4'h4;
      3'h5: exp_g = 4'hC;
      3'h6: exp_g = 4'h8;
      default: exp_g = 4'h9;
    endcase
  endfunction

  // Gates compared once the pin edge has crossed the synchroniser
  task automatic chk_gates(input logic half);
    repeat (6) @(posedge clk);
    `CHK(gates, exp_g(pos, half))
  endtask

  // One step with the bench's own position and count model
  task automatic step_one(input logic d, input sps_mode_t m);
    logic half;
    half = (m == SPS_MODE_HALF);
    ctl_u.pulse(d, m);
    pos = d ? pos - (half ? 3'h1 : 3'h2) : pos + (half ? 3'h1 : 3'h2);
    cnt = cnt + (half ? 1 : 2) * (d ? -1 : 1);
    chk_gates(half);
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    `CHK({bvalid, bresp}, {1'b1, er})
  endtask

  // Bus read: address held until taken, data taken at the valid edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!arready && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    `CHK(rvalid, 1'b1)
  endtask

  // Sequencer reset: gates off while low, first gate alone afterwards
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    fork
      ctl_u.hold_reset(1000);
      begin
        repeat (500) @(posedge clk);
        `CHK(gates, 4'h0)
      end
    join
    pos = 3'h0;
    cnt = 0;
    chk_gates(1'b1);
    axi_rd(`SPS_COUNT_OFS, d, r);
    `CHK(d, 32'h0000_0000)
  endtask

  // Half steps forward through a full cycle and one more, then hold
  task automatic t_half_fwd();
    for (int i = 0; i < 9; i++) begin
      step_one(1'b0, SPS_MODE_HALF);
    end
    repeat (50) @(posedge clk);
    `CHK(gates, exp_g(pos, 1'b1))
  endtask

  // Switch to full steps from an odd position, reverse then forward
  task automatic t_full();
    for (int i = 0; i < 4; i++) begin
      step_one(1'b1, SPS_MODE_FULL);
    end
    for (int i = 0; i < 3; i++) begin
      step_one(1'b0, SPS_MODE_FULL);
    end
  endtask

  // Disable, step while disabled, re-enable at the continued position
  task automatic t_enable();
    ctl_u.set_en(1'b0);
    ctl_u.pulse(1'b0, SPS_MODE_HALF);
    pos = pos + 3'h1;
    cnt++;
    repeat (6) @(posedge clk);
    `CHK(gates, 4'h0)
    ctl_u.set_en(1'b1);
    chk_gates(1'b1);
  endtask

  // Register map: reset value, count, software enable, refused accesses
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`SPS_CTRL_OFS, d, r);
    `CHK({r, d}, {`SPS_RESP_OKAY, 32'h0000_0001})
    axi_rd(`SPS_COUNT_OFS, d, r);
    `CHK(d, 32'(cnt))
    axi_rd(`SPS_STATUS_OFS, d, r);
    `CHK(d[3:0], {1'b1, pos})
    axi_wr(`SPS_CTRL_OFS, 32'h0000_0000, `SPS_RESP_OKAY);
    repeat (4) @(posedge clk);
    `CHK(gates, 4'h0)
    axi_wr(`SPS_CTRL_OFS, 32'h0000_0003, `SPS_RESP_OKAY);
    chk_gates(1'b1);
    // Control write without its low byte lane leaves the gates on
    wstrb <= 4'hE;
    axi_wr(`SPS_CTRL_OFS, 32'h0000_0000, `SPS_RESP_OKAY);
    wstrb <= 4'hF;
    chk_gates(1'b1);
    axi_rd(`SPS_COUNT_OFS, d, r);
    `CHK(d, 32'h0000_0000)
    // Short step pulse: still stepped, error flag set, then cleared
    ctl_u.glitch();
    pos = pos + 3'h1;
    chk_gates(1'b1);
    axi_rd(`SPS_STATUS_OFS, d, r);
    `CHK(d[10:0], {2'b10, exp_g(pos, 1'b1), 1'b0, 1'b1, pos})
    axi_wr(`SPS_CTRL_OFS, 32'h0000_0005, `SPS_RESP_OKAY);
    axi_rd(`SPS_STATUS_OFS, d, r);
    `CHK(d[10], 1'b0)
    axi_wr(`SPS_STATUS_OFS, 32'h0000_0000, `SPS_RESP_SLVERR);
    axi_rd(8'h0C, d, r);
    `CHK({r, d}, {`SPS_RESP_SLVERR, 32'h0000_0000})
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about 2600 cycles
  initial begin
    #100000;
    err_total++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_half_fwd();
    t_full();
    t_enable();
    t_regs();
    t_half_fwd();
    t_reset();
    summarize();
  end
endmodule
